// >>> rtl/ces_channel_enable_sequencer.sv
// four independent channel enable sequencers with pin and command control
//
// How it works
// - four channels, each own sequencing engine
// - request runs channel enable or disable tasks
// - tasks come from image loaded at init
// - control from pins or serial commands
// - general input level change runs event tasks
// - one enable pin per datapath only
// - controls ignored until device primed
// - only event tasks run while only primed
// - pin mode: pin rise enables channel
// - serial mode: enable command enables channel
// - enable holds until told otherwise
`timescale 1ns/1ps
`default_nettype none
module ces_channel_enable_sequencer
	import ces_pkg::*;
#(
	parameter int NUM_CH = CES_NUM_CHANNELS,
	parameter int DEPTH = CES_IMAGE_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// enable pins from the baseband chip
	input wire logic receive_path_one_enable_pin,
	input wire logic receive_path_two_enable_pin,
	input wire logic transmit_path_one_enable_pin,
	input wire logic transmit_path_two_enable_pin,
	// general purpose input watched for events
	input wire logic digital_general_io,
	// priming and mode selection
	input wire logic prime_request,
	input wire logic [NUM_CH-1:0] mode_select,
	// serial command strobes, one bit per channel
	input wire logic [NUM_CH-1:0] spi_enable_cmd,
	input wire logic [NUM_CH-1:0] spi_disable_cmd,
	// image load port: channel, kind (0 enable 1 disable 2 event), slot, word
	input wire logic image_write,
	input wire logic [1:0] image_channel,
	input wire logic [1:0] image_kind,
	input wire logic [CES_TASK_ADDR_W-1:0] image_slot,
	input wire logic [CES_TASK_DATA_W-1:0] image_word,
	// task output towards the datapath
	output logic [NUM_CH-1:0] task_valid,
	output logic [NUM_CH*CES_TASK_DATA_W-1:0] task_word,
	// channel status
	output logic primed,
	output logic [NUM_CH-1:0] radio_active_state,
	output logic [NUM_CH-1:0] sequencer_busy
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	// these inputs are asynchronous to clk, so two stages come before any logic
	logic [NUM_CH:0] pin_meta;
	logic [NUM_CH:0] pin_sync;
	logic [NUM_CH:0] pin_last;
	logic [NUM_CH:0] pin_raw;

	assign pin_raw = {digital_general_io, transmit_path_two_enable_pin,
		transmit_path_one_enable_pin, receive_path_two_enable_pin,
		receive_path_one_enable_pin};

	// first stage is read only by the second stage
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta <= '0;
			pin_sync <= '0;
			pin_last <= '0;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			pin_last <= pin_sync;
		end
	end

	// any level change of the general input counts as one event
	logic gpio_change;
	assign gpio_change = pin_sync[NUM_CH] ^ pin_last[NUM_CH];

	// ****************************************
	// primed state
	// ****************************************
	// sticky: only a reset takes the device out of primed
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			primed <= 1'b0;
		end else if (prime_request) begin
			primed <= 1'b1;
		end
	end

	// ****************************************
	// image row kinds
	// ****************************************
	localparam logic [1:0] KIND_ENABLE = 2'h0;
	localparam logic [1:0] KIND_DISABLE = 2'h1;
	localparam logic [1:0] KIND_EVENT = 2'h2;
	localparam logic [1:0] KIND_UNUSED = 2'h3;

	// ****************************************
	// per channel engines
	// ****************************************
	genvar gc;
	generate
		for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
			// three task series per channel: enable, disable, event
			logic [CES_TASK_DATA_W-1:0] image_mem [3][DEPTH];
			ces_state_type state;
			ces_state_type next_state;
			logic [CES_TASK_ADDR_W-1:0] task_ptr;
			logic [1:0] run_kind;
			logic event_run;
			logic event_pend;
			logic ch_mode;
			logic en_req;
			logic dis_req;
			logic [CES_TASK_DATA_W-1:0] cur_task;
			logic series_done;
			logic start_event;
			logic running;

			// ****************************************
			// task image store
			// ****************************************
			// no reset: the image must be loaded before priming
			always_ff @(posedge clk) begin
				if (image_write && image_channel == 2'(gc) && image_kind != KIND_UNUSED) begin
					image_mem[image_kind][image_slot] <= image_word;
				end
			end

			// ****************************************
			// request source
			// ****************************************
			// mode is only latched while the channel is in the idle or primed state
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					ch_mode <= CES_MODE_RESET;
				end else if (state == CES_ST_PRIMED || state == CES_ST_IDLE) begin
					ch_mode <= mode_select[gc];
				end
			end

			// requests come from the selected source only
			always_comb begin
				if (ch_mode == CES_MODE_PIN) begin
					en_req = pin_sync[gc] && !pin_last[gc];
					dis_req = !pin_sync[gc] && pin_last[gc];
				end else begin
					en_req = spi_enable_cmd[gc];
					dis_req = spi_disable_cmd[gc];
				end
			end

			// ****************************************
			// series progress
			// ****************************************
			// a full image row ends the series even without an end word
			assign cur_task = image_mem[run_kind][task_ptr];
			assign series_done = (cur_task == CES_TASK_END) ||
				(task_ptr == CES_TASK_ADDR_W'(DEPTH - 1));

			// ****************************************
			// channel state machine
			// ****************************************
			always_comb begin
				next_state = state;
				case (state)
					CES_ST_IDLE: begin
						if (primed) begin
							next_state = CES_ST_PRIMED;
						end
					end
					CES_ST_PRIMED: begin
						// an event series in flight holds requests off
						if (en_req && !event_run) begin
							next_state = CES_ST_ENABLING;
						end
					end
					CES_ST_ENABLING: begin
						if (series_done) begin
							next_state = CES_ST_ACTIVE;
						end
					end
					CES_ST_ACTIVE: begin
						if (dis_req && !event_run) begin
							next_state = CES_ST_DISABLING;
						end
					end
					CES_ST_DISABLING: begin
						if (series_done) begin
							next_state = CES_ST_PRIMED;
						end
					end
					default: begin
						next_state = CES_ST_IDLE;
					end
				endcase
			end

			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					state <= CES_ST_IDLE;
				end else begin
					state <= next_state;
				end
			end

			// ****************************************
			// event series
			// ****************************************
			// an event series starts only in a settled state, never against a request
			assign start_event = event_pend && !event_run && next_state == state &&
				(state == CES_ST_PRIMED || state == CES_ST_ACTIVE);

			// a new level change wins over the clear of an older one
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					event_pend <= 1'b0;
				end else if (gpio_change && state != CES_ST_IDLE) begin
					event_pend <= 1'b1;
				end else if (start_event) begin
					event_pend <= 1'b0;
				end
			end

			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					event_run <= 1'b0;
				end else if (start_event) begin
					event_run <= 1'b1;
				end else if (event_run && series_done) begin
					event_run <= 1'b0;
				end
			end

			// ****************************************
			// task pointer
			// ****************************************
			// every series starts again at slot zero
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					task_ptr <= CES_IMAGE_LOAD_RESET;
					run_kind <= KIND_ENABLE;
				end else if (next_state == CES_ST_ENABLING && state != CES_ST_ENABLING) begin
					task_ptr <= CES_IMAGE_LOAD_RESET;
					run_kind <= KIND_ENABLE;
				end else if (next_state == CES_ST_DISABLING && state != CES_ST_DISABLING) begin
					task_ptr <= CES_IMAGE_LOAD_RESET;
					run_kind <= KIND_DISABLE;
				end else if (start_event) begin
					task_ptr <= CES_IMAGE_LOAD_RESET;
					run_kind <= KIND_EVENT;
				end else if (running && !series_done) begin
					task_ptr <= task_ptr + 1'b1;
				end
			end

			assign running = state == CES_ST_ENABLING || state == CES_ST_DISABLING ||
				event_run;

			// ****************************************
			// channel outputs
			// ****************************************
			// the end word closes a series and is never issued
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					task_valid[gc] <= 1'b0;
				end else begin
					task_valid[gc] <= running && cur_task != CES_TASK_END;
				end
			end

			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					task_word[gc*CES_TASK_DATA_W +: CES_TASK_DATA_W] <= CES_TASK_RESET;
				end else begin
					task_word[gc*CES_TASK_DATA_W +: CES_TASK_DATA_W] <= cur_task;
				end
			end

			// taken from next_state so status lands on the edge of the state change
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					radio_active_state[gc] <= 1'b0;
				end else begin
					radio_active_state[gc] <= next_state == CES_ST_ACTIVE;
				end
			end

			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					sequencer_busy[gc] <= 1'b0;
				end else begin
					sequencer_busy[gc] <= next_state == CES_ST_ENABLING ||
						next_state == CES_ST_DISABLING;
				end
			end
		end
	endgenerate

endmodule : ces_channel_enable_sequencer
`default_nettype wire

// >>> rtl/ces_pkg.sv
// package of constants and types for the channel enable sequencer
package ces_pkg;
	localparam int CES_NUM_CHANNELS = 4;
	localparam int CES_CH_RX1 = 0;
	localparam int CES_CH_RX2 = 1;
	localparam int CES_CH_TX1 = 2;
	localparam int CES_CH_TX2 = 3;
	localparam int CES_TASK_ADDR_W = 4;
	localparam int CES_TASK_DATA_W = 16;
	localparam int CES_IMAGE_DEPTH = 16;
	localparam logic [CES_TASK_ADDR_W-1:0] CES_IMAGE_LOAD_RESET = 4'h0;
	localparam logic [CES_TASK_DATA_W-1:0] CES_TASK_END = 16'h0000;
	localparam logic [15:0] CES_TASK_RESET = 16'h0000;
	localparam logic CES_MODE_PIN = 1'b0;
	localparam logic CES_MODE_SPI = 1'b1;
	localparam logic CES_MODE_RESET = CES_MODE_PIN;
	typedef enum logic [4:0] {
		CES_ST_IDLE = 5'b00001,
		CES_ST_PRIMED = 5'b00010,
		CES_ST_ENABLING = 5'b00100,
		CES_ST_ACTIVE = 5'b01000,
		CES_ST_DISABLING = 5'b10000
	} ces_state_type;
endpackage : ces_pkg

// >>> tb/ces_assertions.sv
// port checker for the channel enable sequencer
`timescale 1ns/1ps
`default_nettype none
module ces_assertions #(parameter int NUM_CH = 4) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// pins and commands
	input wire logic receive_path_one_enable_pin,
	input wire logic receive_path_two_enable_pin,
	input wire logic transmit_path_one_enable_pin,
	input wire logic transmit_path_two_enable_pin,
	input wire logic [NUM_CH-1:0] mode_select,
	input wire logic [NUM_CH-1:0] spi_enable_cmd,
	input wire logic [NUM_CH-1:0] spi_disable_cmd,
	// status and tasks
	input wire logic [NUM_CH-1:0] task_valid,
	input wire logic [NUM_CH*16-1:0] task_word,
	input wire logic primed,
	input wire logic [NUM_CH-1:0] radio_active_state,
	input wire logic [NUM_CH-1:0] sequencer_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire [3:0] pins = {transmit_path_two_enable_pin, transmit_path_one_enable_pin,
		receive_path_two_enable_pin, receive_path_one_enable_pin};
	a_primed_sticky: assert property (primed |=> primed)
		else $error("primed fell");
	a_unprimed_quiet: assert property (!primed |-> !(|task_valid))
		else $error("task unprimed");
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		wire idle = !sequencer_busy[i] && !task_valid[i] && !radio_active_state[i];
		// active with busy low must come within 40 cycles of busy
		sequence s_on;
			##[1:6] sequencer_busy[i] ##[1:40] (!sequencer_busy[i] && radio_active_state[i]);
		endsequence
		sequence s_off;
			##[1:40] !radio_active_state[i];
		endsequence
		a_serial_enable: assert property ($past(primed) && mode_select[i]
			&& spi_enable_cmd[i] && idle |-> s_on) else $error("no enable");
		a_pin_enable: assert property ($past(primed) && !mode_select[i]
			&& $rose(pins[i]) && idle |-> s_on) else $error("no pin enable");
		a_serial_disable: assert property (mode_select[i] && spi_disable_cmd[i]
			&& radio_active_state[i] && !sequencer_busy[i] |-> s_off) else $error("no disable");
		a_pin_disable: assert property (!mode_select[i] && $fell(pins[i])
			&& radio_active_state[i] && !sequencer_busy[i] |-> s_off) else $error("no pin off");
		a_end_word_hidden: assert property (task_valid[i] |-> task_word[16*i+:16] != 16'h0000)
			else $error("end word issued");
		a_wrong_source: assert property (!mode_select[i] && spi_enable_cmd[i] && idle
			&& !pins[i] |=> !sequencer_busy[i]) else $error("wrong source");
	end
endmodule : ces_assertions
bind ces_channel_enable_sequencer ces_assertions #(.NUM_CH(NUM_CH)) chk_u (.*);
`default_nettype wire

// >>> tb/ces_bbc_model.sv
// baseband chip model driving the enable pins
`timescale 1ns/1ps
`default_nettype none
module ces_bbc_model (
	// clock
	input wire logic clk,
	// enable pins
	output logic [3:0] pin
);
	initial pin = 4'h0;
	// pins rather than commands: edges land on a known cycle
	task automatic drive(input int c, input logic v);
		@(posedge clk);
		pin[c] <= v;
		#1;
	endtask : drive
endmodule : ces_bbc_model
`default_nettype wire

// >>> tb/ces_channel_enable_sequencer_tb_top.sv
// self-checking bench for the channel enable sequencer
`timescale 1ns/1ps
`default_nettype none
module ces_channel_enable_sequencer_tb_top;
	logic clk = 1'b0, sys_rst = 1'b1, digital_general_io = 1'b0;
	logic prime_request = 1'b0, image_write = 1'b0;
	logic [1:0] image_channel = 2'h0, image_kind = 2'h0;
	logic [3:0] image_slot = 4'h0, spi_enable_cmd = 4'h0, spi_disable_cmd = 4'h0;
	logic [3:0] mode_select = 4'h3;
	logic [15:0] image_word = 16'h0000;
	wire [3:0] pin, task_valid, radio_active_state, sequencer_busy;
	wire [63:0] task_word;
	wire primed;
	int errors = 0, n_tests = 0;
	ces_channel_enable_sequencer dut_u (
		.clk(clk), .sys_rst(sys_rst),
		.receive_path_one_enable_pin(pin[0]), .receive_path_two_enable_pin(pin[1]),
		.transmit_path_one_enable_pin(pin[2]), .transmit_path_two_enable_pin(pin[3]),
		.digital_general_io(digital_general_io), .prime_request(prime_request),
		.mode_select(mode_select), .spi_enable_cmd(spi_enable_cmd),
		.spi_disable_cmd(spi_disable_cmd), .image_write(image_write),
		.image_channel(image_channel), .image_kind(image_kind), .image_slot(image_slot),
		.image_word(image_word), .task_valid(task_valid), .task_word(task_word),
		.primed(primed), .radio_active_state(radio_active_state),
		.sequencer_busy(sequencer_busy));
	ces_bbc_model bbc_u (.clk(clk), .pin(pin));
	always #2.5 clk = ~clk;
	task automatic chk(input logic [63:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic pulse(input logic [3:0] en, dis);
		@(posedge clk);
		spi_enable_cmd <= en;
		spi_disable_cmd <= dis;
		@(posedge clk);
		spi_enable_cmd <= 4'h0;
		spi_disable_cmd <= 4'h0;
		#1;
	endtask : pulse
	// two words of series k on channel c, then the end word
	task automatic seq(input int c, k, input logic r);
		int i;
		i = 0;
		while (task_valid[c] !== 1'b1 && i < 40) begin
			tick(1);
			i++;
		end
		chk(sequencer_busy[c], k < 2);
		for (int s = 0; s < 2; s++) begin
			chk(task_word[16*c+:16], 16'h1000*(k+1)+16'h100*(s+1)+c);
			tick(1);
		end
		chk(task_valid[c], 1'b0);
		tick(2);
		chk(radio_active_state[c], r);
	endtask : seq
	task automatic load_image;
		for (int n = 0; n < 36; n++) begin
			@(posedge clk);
			image_write <= 1'b1;
			image_channel <= 2'(n / 9);
			image_kind <= 2'(n % 9 / 3);
			image_slot <= 4'(n % 3);
			image_word <= (n % 3 == 2) ? 16'h0000
				: 16'(16'h1000 * (n % 9 / 3 + 1) + 16'h100 * (n % 3 + 1) + n / 9);
		end
		@(posedge clk);
		image_write <= 1'b0;
	endtask : load_image
	task automatic t_unprimed;
		pulse(4'h1, 4'h0);
		bbc_u.drive(3, 1'b1);
		tick(10);
		chk(sequencer_busy, 4'h0);
		chk(primed, 1'b0);
		chk(radio_active_state, 4'h0);
		bbc_u.drive(3, 1'b0);
		tick(10);
	endtask : t_unprimed
	task automatic t_event;
		@(posedge clk);
		digital_general_io <= 1'b1;
		#1;
		seq(0, 2, 1'b0);
		tick(10);
	endtask : t_event
	task automatic t_serial;
		pulse(4'h1, 4'h0);
		seq(0, 0, 1'b1);
		chk(radio_active_state, 4'h1);
		tick(200);
		chk(radio_active_state, 4'h1);
		pulse(4'h0, 4'h1);
		seq(0, 1, 1'b0);
	endtask : t_serial
	task automatic t_refused;
		pulse(4'h4, 4'h0);
		bbc_u.drive(1, 1'b1);
		tick(20);
		chk(radio_active_state, 4'h0);
		bbc_u.drive(1, 1'b0);
	endtask : t_refused
	task automatic t_pin;
		bbc_u.drive(3, 1'b1);
		seq(3, 0, 1'b1);
		chk(radio_active_state, 4'h8);
		bbc_u.drive(3, 1'b0);
		seq(3, 1, 1'b0);
	endtask : t_pin
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		load_image;
		t_unprimed;
		@(posedge clk);
		prime_request <= 1'b1;
		tick(3);
		chk(primed, 1'b1);
		t_event;
		t_serial;
		t_refused;
		t_pin;
		complete_run;
	end
	initial begin
		#100000;
		errors++;
		complete_run;
	end
endmodule : ces_channel_enable_sequencer_tb_top
`default_nettype wire
